// ### verilog/conv_pkg.sv
// ****************************************
// shared constants of the converter link
// ****************************************
package conv_pkg;
  // word layout: pad bits then data, msb first
  localparam int unsigned WORD_W = 16;
  localparam int unsigned DATA_W = 12;
  localparam int unsigned PAD_W = 4;
  localparam logic [PAD_W-1:0] PAD_BITS = 4'h0;
  // index of the last bit of a word
  localparam logic [3:0] LAST_BIT = 4'hF;
  // falling edges in one host transmit word
  localparam logic [4:0] TX_BITS = 5'h10;
  // device: link clock cycles per half period of the adc serial clock
  localparam logic [2:0] RCLK_HALF = 3'h4;
  // host: system clock cycles per half period of the dac serial clock
  localparam logic [2:0] DAC_SERIAL_CLOCK_IN_HALF = 3'h4;
  // host: cycles the start and load strobes stay low
  localparam logic [3:0] START_LOW = 4'h8;
  localparam logic [3:0] LOAD_LOW = 4'h8;
  // values after reset
  localparam logic [DATA_W-1:0] DAC_CODE_RST = 12'h000;
  localparam logic PIN_IDLE = 1'b1;
  // device adc sequencer
  typedef enum logic [1:0] {
    ADC_IDLE = 2'b01,
    ADC_SHIFT = 2'b10
  } adc_state_t;
  // host transmit sequencer
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_WAIT = 3'b010,
    TX_SHIFT = 3'b100
  } tx_state_t;
endpackage

// ### verilog/conv_link_if.sv
`timescale 1ns/1ps
// ****************************************
// serial pins between host and converter
// ****************************************
interface conv_link_if;
  // host driven pins
  logic conversion_start_n;
  logic dac_load_strobe_n;
  logic dac_serial_clock_in;
  logic dac_frame_sync_n;
  logic dac_serial_data_in;
  // open-drain drivers of the device
  logic adc_clk_o;
  logic adc_clk_oe;
  logic adc_frame_o;
  logic adc_frame_oe;
  logic adc_data_o;
  logic adc_data_oe;
  // resolved open-drain wires, pull-ups give the high level
  logic adc_serial_clock;
  logic adc_frame_strobe_n;
  logic adc_serial_data_out;
  assign adc_serial_clock = adc_clk_oe ? adc_clk_o : 1'b1;
  assign adc_frame_strobe_n = adc_frame_oe ? adc_frame_o : 1'b1;
  assign adc_serial_data_out = adc_data_oe ? adc_data_o : 1'b1;
  // documented device end
  modport dev (
    input conversion_start_n, dac_load_strobe_n, dac_serial_clock_in,
    input dac_frame_sync_n, dac_serial_data_in,
    output adc_clk_o, adc_clk_oe, adc_frame_o, adc_frame_oe,
    output adc_data_o, adc_data_oe
  );
  // processor serial port end
  modport host (
    output conversion_start_n, dac_load_strobe_n, dac_serial_clock_in,
    output dac_frame_sync_n, dac_serial_data_in,
    input adc_serial_clock, adc_frame_strobe_n, adc_serial_data_out
  );
endinterface

// ### verilog/conv_device.sv
`timescale 1ns/1ps
// What this block does
// - rising start edge begins conversion, enters hold
// - word is four zeros then 12-bit result
// - data changes on rising clock, sampled falling
// - frame low at start, bit valid first fall
// - clock, frame and data are open-drain
// - serial clock derived from adc master clock
// - continuity input selects free-running serial clock
// - noncontinuous clock released after each conversion
// - input latch and dac latch, latter drives output
// - host presents data valid at falling edge
// - frame sync starts exactly sixteen shifted bits
// - first four bits dropped, twelve msb first kept
// - load strobe falling edge copies input latch
// - load held low updates on sixteenth edge
// - load falling mid-word does not update
// - load low through word end updates at end
// - load back high before end: no update
// - codes are two's complement, zero is 000
// - host keeps frame sync high between words
module conv_device (
  // adc master clock, also the link clock of this end
  input wire logic link_clk,
  input wire logic rstn,
  // converter pins
  conv_link_if.dev link,
  // converter core side
  input wire logic [conv_pkg::DATA_W-1:0] adc_sample,
  input wire logic clock_continuous,
  output logic hold_mode,
  output logic [conv_pkg::DATA_W-1:0] dac_code,
  output logic dac_update
);
  import conv_pkg::*;

  // ****************************************
  // reset and pin synchronisers
  // ****************************************
  logic rst_meta; // first stage of reset synchroniser
  logic rst_sync_n; // reset in the link clock domain
  logic [5:0] pin_meta; // first stage, read by pin_sync only
  logic [5:0] pin_sync; // second stage, safe to use
  logic cs_s; // synchronised start strobe
  logic ld_s; // synchronised load strobe
  logic tck_s; // synchronised dac serial clock
  logic tfs_s; // synchronised frame sync
  logic dt_s; // synchronised serial data
  logic cont_s; // synchronised continuity select

  // two flops on every level coming from outside this clock
  always_ff @(posedge link_clk) begin
    rst_meta <= rstn;
    rst_sync_n <= rst_meta;
    pin_meta <= {link.conversion_start_n, link.dac_load_strobe_n,
                 link.dac_serial_clock_in, link.dac_frame_sync_n,
                 link.dac_serial_data_in, clock_continuous};
    pin_sync <= pin_meta;
  end

  assign {cs_s, ld_s, tck_s, tfs_s, dt_s, cont_s} = pin_sync;

  // ****************************************
  // edge detection
  // ****************************************
  logic cs_prev_reg; // start strobe one cycle ago
  logic ld_prev_reg; // load strobe one cycle ago
  logic tck_prev_reg; // dac clock one cycle ago
  logic cs_rise; // start strobe went high
  logic ld_fall; // load strobe went low
  logic tck_fall; // dac clock went low

  // idle-high history so reset does not fake an edge
  always_ff @(posedge link_clk) begin
    if (!rst_sync_n) begin
      cs_prev_reg <= PIN_IDLE;
      ld_prev_reg <= PIN_IDLE;
      tck_prev_reg <= PIN_IDLE;
    end else begin
      cs_prev_reg <= cs_s;
      ld_prev_reg <= ld_s;
      tck_prev_reg <= tck_s;
    end
  end

  assign cs_rise = ~cs_prev_reg & cs_s;
  assign ld_fall = ld_prev_reg & ~ld_s;
  assign tck_fall = tck_prev_reg & ~tck_s;

  // ****************************************
  // adc serial transmitter
  // ****************************************
  adc_state_t adc_state_reg, adc_state_next; // sequencer state
  logic [2:0] div_reg, div_next; // serial clock divider
  logic rclk_reg, rclk_next; // serial clock level, 1 = released
  logic frame_n_reg, frame_n_next; // frame strobe level
  logic [3:0] bit_reg, bit_next; // bit being sent
  logic [WORD_W-1:0] sh_reg, sh_next; // outgoing word, msb on the pin
  logic hold_reg, hold_next; // track/hold in hold mode
  logic rclk_tick; // half period of the serial clock done

  assign rclk_tick = (div_reg == RCLK_HALF - 3'h1);

  // next state of the transmitter
  always_comb begin
    adc_state_next = adc_state_reg;
    div_next = rclk_tick ? 3'h0 : div_reg + 3'h1;
    rclk_next = rclk_reg;
    frame_n_next = frame_n_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    hold_next = hold_reg;
    unique case (adc_state_reg)
      ADC_IDLE: begin
        // free-running or parked serial clock between words
        if (cont_s) begin
          if (rclk_tick) begin
            rclk_next = ~rclk_reg;
          end
        end else begin
          rclk_next = 1'b1;
        end
        // start edge: hold, frame low, first zero on the pin
        if (cs_rise) begin
          adc_state_next = ADC_SHIFT;
          hold_next = 1'b1;
          frame_n_next = 1'b0;
          sh_next = {PAD_BITS, adc_sample};
          bit_next = 4'h0;
          rclk_next = 1'b1;
          div_next = 3'h0;
        end
      end
      ADC_SHIFT: begin
        if (rclk_tick) begin
          if (rclk_reg) begin
            // falling edge, the host samples here
            rclk_next = 1'b0;
          end else if (bit_reg == LAST_BIT) begin
            // word done: end of conversion
            adc_state_next = ADC_IDLE;
            frame_n_next = 1'b1;
            hold_next = 1'b0;
            rclk_next = 1'b1;
          end else begin
            // rising edge moves the next bit out
            rclk_next = 1'b1;
            bit_next = bit_reg + 4'h1;
            sh_next = {sh_reg[WORD_W-2:0], 1'b0};
          end
        end
      end
      default: begin
        adc_state_next = ADC_IDLE;
      end
    endcase
  end

  // transmitter registers
  always_ff @(posedge link_clk) begin
    if (!rst_sync_n) begin
      adc_state_reg <= ADC_IDLE;
      div_reg <= 3'h0;
      rclk_reg <= PIN_IDLE;
      frame_n_reg <= PIN_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= {WORD_W{1'b1}};
      hold_reg <= 1'b0;
    end else begin
      adc_state_reg <= adc_state_next;
      div_reg <= div_next;
      rclk_reg <= rclk_next;
      frame_n_reg <= frame_n_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      hold_reg <= hold_next;
    end
  end

  // open-drain pins only ever pull low
  assign link.adc_clk_o = 1'b0;
  assign link.adc_clk_oe = ~rclk_reg;
  assign link.adc_frame_o = 1'b0;
  assign link.adc_frame_oe = ~frame_n_reg;
  assign link.adc_data_o = 1'b0;
  assign link.adc_data_oe = ~frame_n_reg & ~sh_reg[WORD_W-1];
  assign hold_mode = hold_reg;

  // ****************************************
  // dac serial receiver and latches
  // ****************************************
  logic rx_busy_reg, rx_busy_next; // word being shifted in
  logic armed_reg, armed_next; // frame sync seen high since last word
  logic [3:0] rx_cnt_reg, rx_cnt_next; // bits taken in this word
  logic [DATA_W-1:0] rx_sh_reg, rx_sh_next; // shifter, pad bits fall out
  logic [DATA_W-1:0] in_latch_reg, in_latch_next; // input latch
  logic [DATA_W-1:0] dac_reg, dac_next; // dac latch
  logic upd_reg, upd_next; // dac latch written
  logic [DATA_W-1:0] rx_word; // word completed by this edge

  assign rx_word = {rx_sh_reg[DATA_W-2:0], dt_s};

  // next state of the receiver and both latches
  always_comb begin
    rx_busy_next = rx_busy_reg;
    armed_next = armed_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_sh_next = rx_sh_reg;
    in_latch_next = in_latch_reg;
    dac_next = dac_reg;
    upd_next = 1'b0;
    // frame sync high again lets a new word start
    if (tfs_s) begin
      armed_next = 1'b1;
    end
    if (tck_fall && (rx_busy_reg || (!tfs_s && armed_reg))) begin
      // take one bit on each of the sixteen falling edges
      rx_busy_next = 1'b1;
      armed_next = 1'b0;
      rx_sh_next = rx_word;
      rx_cnt_next = rx_cnt_reg + 4'h1;
      if (rx_cnt_reg == LAST_BIT) begin
        // sixteenth edge completes the input latch
        rx_busy_next = 1'b0;
        in_latch_next = rx_word;
        if (!ld_s) begin
          // load held low: update now with the new word
          dac_next = rx_word;
          upd_next = 1'b1;
        end
      end
    end else if (ld_fall && !rx_busy_reg) begin
      // plain load edge outside a word
      dac_next = in_latch_reg;
      upd_next = 1'b1;
    end
  end

  // receiver registers
  always_ff @(posedge link_clk) begin
    if (!rst_sync_n) begin
      rx_busy_reg <= 1'b0;
      armed_reg <= 1'b0;
      rx_cnt_reg <= 4'h0;
      rx_sh_reg <= DAC_CODE_RST;
      in_latch_reg <= DAC_CODE_RST;
      dac_reg <= DAC_CODE_RST;
      upd_reg <= 1'b0;
    end else begin
      rx_busy_reg <= rx_busy_next;
      armed_reg <= armed_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_sh_reg <= rx_sh_next;
      in_latch_reg <= in_latch_next;
      dac_reg <= dac_next;
      upd_reg <= upd_next;
    end
  end

  // only the dac latch reaches the converter
  assign dac_code = dac_reg;
  assign dac_update = upd_reg;
endmodule

// ### verilog/conv_host.sv
`timescale 1ns/1ps
module conv_host (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // converter pins
  conv_link_if.host link,
  // conversion request and result
  input wire logic start_req,
  output logic [conv_pkg::DATA_W-1:0] adc_word,
  output logic adc_valid,
  // dac word handshake and load control
  input wire logic [conv_pkg::DATA_W-1:0] dac_word,
  input wire logic dac_valid,
  output logic dac_ready,
  input wire logic load_req,
  input wire logic load_hold
);
  import conv_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] pin_meta; // first stage, read by pin_sync only
  logic [2:0] pin_sync; // second stage
  logic rclk_s; // synchronised adc serial clock
  logic rfs_s; // synchronised adc frame strobe
  logic dr_s; // synchronised adc data

  // the adc pins come from the link clock domain
  always_ff @(posedge clk_sys) begin
    pin_meta <= {link.adc_serial_clock, link.adc_frame_strobe_n,
                 link.adc_serial_data_out};
    pin_sync <= pin_meta;
  end

  assign {rclk_s, rfs_s, dr_s} = pin_sync;

  // ****************************************
  // adc receiver and strobes
  // ****************************************
  logic rclk_prev_reg, rclk_prev_next; // serial clock one cycle ago
  logic [3:0] rx_cnt_reg, rx_cnt_next; // bits taken
  logic [DATA_W-1:0] rx_sh_reg, rx_sh_next; // shifter, leading zeros fall out
  logic [DATA_W-1:0] word_reg, word_next; // last result
  logic valid_reg, valid_next; // result pulse
  logic [3:0] cs_cnt_reg, cs_cnt_next; // start strobe low time left
  logic cs_n_reg, cs_n_next; // start strobe pin
  logic [3:0] ld_cnt_reg, ld_cnt_next; // load strobe low time left
  logic ld_n_reg, ld_n_next; // load strobe pin

  // next state of receiver and strobes
  always_comb begin
    rclk_prev_next = rclk_s;
    rx_cnt_next = rx_cnt_reg;
    rx_sh_next = rx_sh_reg;
    word_next = word_reg;
    valid_next = 1'b0;
    // sample on falling serial clock while framed
    if (rfs_s) begin
      rx_cnt_next = 4'h0;
    end else if (rclk_prev_reg && !rclk_s) begin
      rx_sh_next = {rx_sh_reg[DATA_W-2:0], dr_s};
      rx_cnt_next = rx_cnt_reg + 4'h1;
      if (rx_cnt_reg == LAST_BIT) begin
        word_next = {rx_sh_reg[DATA_W-2:0], dr_s};
        valid_next = 1'b1;
      end
    end
    // start strobe: low pulse, conversion starts on its rise
    cs_cnt_next = cs_cnt_reg;
    if (cs_cnt_reg != 4'h0) begin
      cs_cnt_next = cs_cnt_reg - 4'h1;
    end else if (start_req) begin
      cs_cnt_next = START_LOW;
    end
    cs_n_next = (cs_cnt_next == 4'h0);
    // load strobe: low pulse or held low
    ld_cnt_next = ld_cnt_reg;
    if (ld_cnt_reg != 4'h0) begin
      ld_cnt_next = ld_cnt_reg - 4'h1;
    end else if (load_req) begin
      ld_cnt_next = LOAD_LOW;
    end
    ld_n_next = !load_hold && (ld_cnt_next == 4'h0);
  end

  // receiver and strobe registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rclk_prev_reg <= PIN_IDLE;
      rx_cnt_reg <= 4'h0;
      rx_sh_reg <= DAC_CODE_RST;
      word_reg <= DAC_CODE_RST;
      valid_reg <= 1'b0;
      cs_cnt_reg <= 4'h0;
      cs_n_reg <= PIN_IDLE;
      ld_cnt_reg <= 4'h0;
      ld_n_reg <= PIN_IDLE;
    end else begin
      rclk_prev_reg <= rclk_prev_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_sh_reg <= rx_sh_next;
      word_reg <= word_next;
      valid_reg <= valid_next;
      cs_cnt_reg <= cs_cnt_next;
      cs_n_reg <= cs_n_next;
      ld_cnt_reg <= ld_cnt_next;
      ld_n_reg <= ld_n_next;
    end
  end

  assign adc_word = word_reg;
  assign adc_valid = valid_reg;
  assign link.conversion_start_n = cs_n_reg;
  assign link.dac_load_strobe_n = ld_n_reg;

  // ****************************************
  // dac transmitter
  // ****************************************
  tx_state_t tx_state_reg, tx_state_next; // sequencer state
  logic [2:0] tdiv_reg, tdiv_next; // serial clock divider
  logic dac_serial_clock_in_reg, dac_serial_clock_in_next; // serial clock pin
  logic [WORD_W-1:0] tx_sh_reg, tx_sh_next; // outgoing word, msb on pin
  logic [4:0] tx_cnt_reg, tx_cnt_next; // falling edges sent
  logic tfs_n_reg, tfs_n_next; // frame sync pin
  logic tick; // half period done
  logic rise; // serial clock about to rise
  logic fall; // serial clock about to fall

  assign tick = (tdiv_reg == DAC_SERIAL_CLOCK_IN_HALF - 3'h1);
  assign rise = tick & ~dac_serial_clock_in_reg;
  assign fall = tick & dac_serial_clock_in_reg;
  assign dac_ready = (tx_state_reg == TX_IDLE);

  // next state of the transmitter
  always_comb begin
    tx_state_next = tx_state_reg;
    tdiv_next = tick ? 3'h0 : tdiv_reg + 3'h1;
    dac_serial_clock_in_next = tick ? ~dac_serial_clock_in_reg : dac_serial_clock_in_reg;
    tx_sh_next = tx_sh_reg;
    tx_cnt_next = tx_cnt_reg;
    tfs_n_next = tfs_n_reg;
    unique case (tx_state_reg)
      TX_IDLE: begin
        // take a word, pad bits lead
        if (dac_valid) begin
          tx_sh_next = {PAD_BITS, dac_word};
          tx_state_next = TX_WAIT;
        end
      end
      TX_WAIT: begin
        // frame opens on a rising edge, msb already on the pin
        if (rise) begin
          tfs_n_next = 1'b0;
          tx_cnt_next = 5'h00;
          tx_state_next = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (fall) begin
          tx_cnt_next = tx_cnt_reg + 5'h01;
        end else if (rise) begin
          if (tx_cnt_reg == TX_BITS) begin
            // frame sync back high between words
            tfs_n_next = 1'b1;
            tx_state_next = TX_IDLE;
          end else begin
            tx_sh_next = {tx_sh_reg[WORD_W-2:0], 1'b0};
          end
        end
      end
      default: begin
        tx_state_next = TX_IDLE;
      end
    endcase
  end

  // transmitter registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tx_state_reg <= TX_IDLE;
      tdiv_reg <= 3'h0;
      dac_serial_clock_in_reg <= PIN_IDLE;
      tx_sh_reg <= {WORD_W{1'b0}};
      tx_cnt_reg <= 5'h00;
      tfs_n_reg <= PIN_IDLE;
    end else begin
      tx_state_reg <= tx_state_next;
      tdiv_reg <= tdiv_next;
      dac_serial_clock_in_reg <= dac_serial_clock_in_next;
      tx_sh_reg <= tx_sh_next;
      tx_cnt_reg <= tx_cnt_next;
      tfs_n_reg <= tfs_n_next;
    end
  end

  assign link.dac_serial_clock_in = dac_serial_clock_in_reg;
  assign link.dac_frame_sync_n = tfs_n_reg;
  assign link.dac_serial_data_in = tx_sh_reg[WORD_W-1];
endmodule

// ### tb/conv_link_asserts.sv
`timescale 1ns/1ps
// ****************************************
// link protocol checker
// ****************************************
module conv_link_asserts (
  // clocks and reset
  input wire logic clk_sys,
  input wire logic link_clk,
  input wire logic rstn,
  // device core setting
  input wire logic clock_continuous,
  // host driven pins
  input wire logic conversion_start_n,
  input wire logic dac_serial_clock_in,
  input wire logic dac_frame_sync_n,
  input wire logic dac_serial_data_in,
  // device open-drain drivers
  input wire logic adc_clk_o,
  input wire logic adc_clk_oe,
  input wire logic adc_frame_o,
  input wire logic adc_frame_oe,
  input wire logic adc_data_o,
  input wire logic adc_data_oe,
  // resolved adc wires
  input wire logic adc_serial_clock,
  input wire logic adc_frame_strobe_n,
  input wire logic adc_serial_data_out
);
  // last clock levels and falling edges seen inside the current frame
  logic rclk_reg, rclk_next, dac_serial_clock_in_reg, dac_serial_clock_in_next;
  logic [4:0] rfall_reg, rfall_next, tfall_reg, tfall_next;
  // next values: counts restart while a frame is idle
  always_comb begin
    rclk_next = rstn ? adc_serial_clock : 1'b1;
    dac_serial_clock_in_next = rstn ? dac_serial_clock_in : 1'b1;
    rfall_next = rfall_reg + {4'h0, rclk_reg & ~adc_serial_clock};
    tfall_next = tfall_reg + {4'h0, dac_serial_clock_in_reg & ~dac_serial_clock_in};
    if (!rstn || adc_frame_strobe_n) begin
      rfall_next = 5'h00;
    end
    if (!rstn || dac_frame_sync_n) begin
      tfall_next = 5'h00;
    end
  end
  // device side registers
  always_ff @(posedge link_clk) begin
    rclk_reg <= rclk_next;
    rfall_reg <= rfall_next;
  end
  // host side registers
  always_ff @(posedge clk_sys) begin
    dac_serial_clock_in_reg <= dac_serial_clock_in_next;
    tfall_reg <= tfall_next;
  end
  // low half of the adc serial clock, then the rise
  sequence s_low_half;
    !adc_serial_clock [*4] ##1 adc_serial_clock;
  endsequence
  // one full dac clock period with frame sync idle
  sequence s_gap;
    dac_frame_sync_n [*8];
  endsequence
  property p_start_frame;
    @(posedge link_clk) disable iff (!rstn)
    $rose(conversion_start_n) && adc_frame_strobe_n |-> ##[1:5] !adc_frame_strobe_n;
  endproperty
  a_start_frame: assert property (p_start_frame) else $error("no frame after start");
  property p_data_edge;
    @(posedge link_clk) disable iff (!rstn)
    !adc_frame_strobe_n && !$past(adc_frame_strobe_n) && $changed(adc_serial_data_out)
      |-> $rose(adc_serial_clock);
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("adc data moved off rise");
  property p_clk_half;
    @(posedge link_clk) disable iff (!rstn)
    !adc_frame_strobe_n && $fell(adc_serial_clock) |-> s_low_half;
  endproperty
  a_clk_half: assert property (p_clk_half) else $error("adc clock half wrong");
  property p_lead_zero;
    @(posedge link_clk) disable iff (!rstn)
    !adc_frame_strobe_n && $fell(adc_serial_clock) && rfall_reg < 5'h04 |-> !adc_serial_data_out;
  endproperty
  a_lead_zero: assert property (p_lead_zero) else $error("lead bit not zero");
  property p_word_len;
    @(posedge link_clk) disable iff (!rstn)
    $rose(adc_frame_strobe_n) |-> rfall_reg == 5'h10;
  endproperty
  a_word_len: assert property (p_word_len) else $error("adc word length");
  property p_released;
    @(posedge link_clk) disable iff (!rstn)
    adc_frame_strobe_n && $past(adc_frame_strobe_n) && !clock_continuous
      && !$past(clock_continuous, 6) |-> !adc_clk_oe;
  endproperty
  a_released: assert property (p_released) else $error("adc clock not released");
  property p_open_drain;
    @(posedge link_clk) disable iff (!rstn)
    !(adc_clk_oe && adc_clk_o) && !(adc_frame_oe && adc_frame_o) && !(adc_data_oe && adc_data_o)
      && (!adc_data_oe || adc_frame_oe);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("driver pulls high");
  property p_tx_start;
    @(posedge clk_sys) disable iff (!rstn)
    $fell(dac_frame_sync_n) |-> $rose(dac_serial_clock_in);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("frame sync off rise");
  property p_tx_data;
    @(posedge clk_sys) disable iff (!rstn)
    !dac_frame_sync_n && $changed(dac_serial_data_in) |-> $rose(dac_serial_clock_in);
  endproperty
  a_tx_data: assert property (p_tx_data) else $error("dac data moved off rise");
  property p_tx_len;
    @(posedge clk_sys) disable iff (!rstn)
    $rose(dac_frame_sync_n) |-> tfall_reg == 5'h10 ##0 s_gap;
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("dac word length or gap");
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  import conv_pkg::*;
  // clocks, stimulus and results
  logic clk_sys, link_clk, rstn, start_req, dac_valid, load_req, load_hold, clock_continuous;
  logic adc_valid, hold_mode, dac_update, dac_ready;
  logic [DATA_W-1:0] adc_sample, adc_word, dac_word, dac_code;
  int fail_count, check_count, cycles, n, upd_count;
  conv_link_if link ();
  conv_host i_conv_host (.clk_sys(clk_sys), .rstn(rstn), .link(link), .start_req(start_req),
    .adc_word(adc_word), .adc_valid(adc_valid), .dac_word(dac_word), .dac_valid(dac_valid),
    .dac_ready(dac_ready), .load_req(load_req), .load_hold(load_hold));
  conv_device i_conv_device (.link_clk(link_clk), .rstn(rstn), .link(link),
    .adc_sample(adc_sample), .clock_continuous(clock_continuous), .hold_mode(hold_mode),
    .dac_code(dac_code), .dac_update(dac_update));
  conv_link_asserts i_conv_link_asserts (.clk_sys(clk_sys), .link_clk(link_clk), .rstn(rstn),
    .clock_continuous(clock_continuous), .conversion_start_n(link.conversion_start_n),
    .dac_serial_clock_in(link.dac_serial_clock_in), .dac_frame_sync_n(link.dac_frame_sync_n),
    .dac_serial_data_in(link.dac_serial_data_in), .adc_clk_o(link.adc_clk_o),
    .adc_clk_oe(link.adc_clk_oe), .adc_frame_o(link.adc_frame_o),
    .adc_frame_oe(link.adc_frame_oe), .adc_data_o(link.adc_data_o),
    .adc_data_oe(link.adc_data_oe), .adc_serial_clock(link.adc_serial_clock),
    .adc_frame_strobe_n(link.adc_frame_strobe_n),
    .adc_serial_data_out(link.adc_serial_data_out));
  // system clock, 20 ns
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // adc master clock, 15 ns, offset phase
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  // move one or more cycles, then drive just after the edge
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  // compare and count
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
    input string msg);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  // status signal chosen by number
  function automatic logic pick(input int which);
    case (which)
      0: return hold_mode;
      1: return adc_valid;
      2: return dac_ready;
      default: return link.adc_serial_clock;
    endcase
  endfunction
  // bounded wait for a level
  task automatic wait_on(input int which, input logic lvl, input string msg);
    int k;
    k = 0;
    while (pick(which) !== lvl && k < 400) begin
      step(1);
      k++;
    end
    check({11'h000, pick(which)}, {11'h000, lvl}, msg);
  endtask
  // one conversion with a known result
  task automatic adc_conv(input logic [DATA_W-1:0] s);
    adc_sample = s;
    start_req = 1'b1;
    step(1);
    start_req = 1'b0;
    wait_on(0, 1'b1, "no hold");
    wait_on(1, 1'b1, "no result");
    check(adc_word, s, "adc word");
    wait_on(0, 1'b0, "hold stuck");
  endtask
  // hand a word to the host transmitter
  task automatic dac_start(input logic [DATA_W-1:0] w);
    wait_on(2, 1'b1, "not ready");
    dac_word = w;
    dac_valid = 1'b1;
    step(1);
    dac_valid = 1'b0;
  endtask
  // wait for the word to end and the device to settle
  task automatic dac_end();
    step(1);
    wait_on(2, 1'b1, "tx stuck");
    step(12);
  endtask
  // one load strobe pulse
  task automatic load_pulse();
    load_req = 1'b1;
    step(1);
    load_req = 1'b0;
  endtask
  // verdict
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // dac latch writes, counted in the device clock so no pulse is missed
  always @(posedge link_clk) upd_count += dac_update;
  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      $display("unexpected at %0t: timeout", $time);
      test_done();
    end
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    {start_req, dac_valid, load_req, load_hold, clock_continuous} = 5'h00;
    adc_sample = 12'h000;
    dac_word = 12'h000;
    step(3);
    rstn = 1'b1;
    step(6);
    check(dac_code, DAC_CODE_RST, "dac reset");
    check(adc_word, 12'h000, "adc reset");
    adc_conv(12'h7FF);
    adc_conv(12'h800);
    adc_conv(12'h000);
    adc_conv(12'hA5C);
    $display("test adc words done");
    clock_continuous = 1'b1;
    step(10);
    adc_conv(12'h3C1);
    wait_on(3, 1'b0, "no free clock");
    clock_continuous = 1'b0;
    step(20);
    n = 0;
    repeat (40) begin
      step(1);
      n += (link.adc_serial_clock !== 1'b1);
    end
    check(n[11:0], 12'h000, "clock not parked");
    $display("test clock modes done");
    dac_start(12'h123);
    dac_end();
    check(dac_code, DAC_CODE_RST, "latched early");
    load_pulse();
    step(12);
    check(dac_code, 12'h123, "load copy");
    load_hold = 1'b1;
    dac_start(12'h7FF);
    dac_end();
    check(dac_code, 12'h7FF, "held load");
    dac_start(12'h800);
    dac_end();
    check(dac_code, 12'h800, "held load");
    load_hold = 1'b0;
    step(12);
    dac_start(12'h456);
    step(40);
    load_hold = 1'b1;
    step(12);
    check(dac_code, 12'h800, "mid word update");
    dac_end();
    check(dac_code, 12'h456, "end of word update");
    load_hold = 1'b0;
    step(12);
    dac_start(12'h321);
    step(40);
    load_pulse();
    dac_end();
    check(dac_code, 12'h456, "aborted load");
    check(upd_count[11:0], 12'h005, "update count");
    $display("test dac loads done");
    test_done();
  end
endmodule
